// file: spd_step_pulse_input_decoder.sv
/*
 * step pulse input decoder: pins to microsteps,
 * position, current and faults.
 * assumes async pins and fault lines,
 * and a one-cycle strobe master.
 */
// The implementer's own choices: the strobed register port and the register addresses.
// Behaviour
// R1 - single mode: one step per selected step edge
// R2 - double mode: step pin is clockwise pulse, level selectable
// R3 - single mode: static direction level picks rotation
// R4 - double mode: direction pin is counter-clockwise pulse, level selectable
// R5 - enable high runs; polarity invertible; open input enabled
// R6 - reset gives single mode, rising edge
// R7 - software selects single or double mode
// R8 - auto idle cuts current to 60% when steps stop
// R9 - resolution from full step to 102,400 per rev
// R10 - steps up to 200 kHz; host stays below
// R11 - input steps spread into timed microsteps
// R12 - any sensor fault forces protective state
// R13 - signed microstep position; no steps when off or faulted
`include "spd_params.svh"

module spd_step_pulse_input_decoder #(
    parameter int unsigned IDLE_CYC = `SPD_IDLE_CYC,
    parameter int unsigned MIN_GAP_CYC = `SPD_MIN_GAP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command pins from the host
    input wire logic step_pulse_in,
    input wire logic dir_in,
    input wire logic drive_enable_in,
    // protection sensors
    input wire logic over_voltage_in,
    input wire logic over_current_in,
    input wire logic phase_error_in,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // motion outputs to the current controller
    output logic microstep_pulse,
    output logic microstep_dir,
    output logic [7:0] cmd_current,
    output logic drive_active,
    output logic fault_active,
    // interrupt
    output logic irq
);

    // ------------------------------
    // declarations
    // ------------------------------
    localparam int PINS = 6;
    logic [PINS-1:0] pin_raw;
    logic [PINS-1:0] meta_q;
    logic [PINS-1:0] sync_q;
    logic [PINS-1:0] prev_q;
    spd_pkg::spd_ctrl_t ctrl_q;
    spd_pkg::spd_state_t state_q;
    spd_pkg::spd_evt_t evt;
    logic [4:0] status_q;
    logic [4:0] int_en_q;
    logic [9:0] mult_q;
    logic [16:0] res_q;
    logic [7:0] run_cur_q;
    logic [15:0] interp_q;
    logic [15:0] tick_cnt_q;
    logic signed [23:0] pending_q;
    logic signed [31:0] pos_q;
    logic [31:0] idle_cnt_q;
    logic [31:0] gap_cnt_q;
    logic [7:0] idle_cur;
    logic [13:0] idle_prod;
    logic wr_ctrl;
    logic fault_clr;
    logic pos_clr;
    logic fault_now;
    logic enabled;
    logic moving;
    logic single_edge;
    logic cw_edge;
    logic ccw_edge;
    logic in_step;
    logic in_fwd;
    logic accept;
    logic tick;
    logic emit;
    logic idle_done;
    logic signed [23:0] add_val;
    logic signed [23:0] sub_val;

    // ------------------------------
    // pin synchronisers
    // ------------------------------
    assign pin_raw = {phase_error_in, over_current_in, over_voltage_in,
                      drive_enable_in, dir_in, step_pulse_in};

    // two sync flops and one edge flop per pin; the first stage feeds no logic
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end
                else
                begin
                    meta_q[gi] <= pin_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                    prev_q[gi] <= sync_q[gi];
                end
            end
        end
    endgenerate

    // ------------------------------
    // command decoding
    // ------------------------------
    // single mode: step_fall picks the falling edge
    assign single_edge = ctrl_q.step_fall ? (prev_q[0] & ~sync_q[0])
                                          : (sync_q[0] & ~prev_q[0]); // R1
    // double mode: step_fall doubles as clockwise active-low select
    assign cw_edge = (sync_q[0] ^ ctrl_q.step_fall) & ~(prev_q[0] ^ ctrl_q.step_fall); // R2
    assign ccw_edge = (sync_q[1] ^ ctrl_q.ccw_low) & ~(prev_q[1] ^ ctrl_q.ccw_low); // R4
    // coincident pulses cancel
    assign in_step = ctrl_q.double_mode ? (cw_edge ^ ccw_edge) : single_edge; // R7
    assign in_fwd = ctrl_q.double_mode ? cw_edge : (sync_q[1] ^ ctrl_q.dir_invert); // R3
    // an open input reads high, hence enabled while ena_invert is clear
    assign enabled = sync_q[2] ^ ctrl_q.ena_invert; // R5
    assign fault_now = |sync_q[5:3];
    assign moving = (state_q == spd_pkg::SPD_RUN) || (state_q == spd_pkg::SPD_STANDBY);
    assign accept = in_step & moving; // R13

    // ------------------------------
    // register write decode
    // ------------------------------
    assign wr_ctrl = reg_wr && (reg_addr == `SPD_REG_CTRL);
    assign fault_clr = wr_ctrl && reg_wdata[`SPD_CTRL_FAULT_CLR];
    assign pos_clr = wr_ctrl && reg_wdata[`SPD_CTRL_POS_CLR];

    // control word
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl_q <= `SPD_CTRL_RST; // R6
        else if (wr_ctrl)
            ctrl_q <= reg_wdata[5:0]; // R7
    end

    // clamped so a bad write cannot stall motion
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mult_q <= `SPD_MULT_RST;
            res_q <= `SPD_RES_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `SPD_REG_MULT)
            begin
                if (reg_wdata[31:0] > {22'h000000, `SPD_MULT_MAX})
                    mult_q <= `SPD_MULT_MAX;
                else if (reg_wdata[9:0] == 10'h000)
                    mult_q <= 10'h001;
                else
                    mult_q <= reg_wdata[9:0];
            end
            if (reg_addr == `SPD_REG_RES)
            begin
                if (reg_wdata[31:0] < {15'h0000, `SPD_RES_MIN})
                    res_q <= `SPD_RES_MIN; // R9
                else if (reg_wdata[31:0] > {15'h0000, `SPD_RES_MAX})
                    res_q <= `SPD_RES_MAX; // R9
                else
                    res_q <= reg_wdata[16:0];
            end
        end
    end

    // running current and microstep spacing
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            run_cur_q <= `SPD_RUN_CUR_RST;
            interp_q <= `SPD_INTERP_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `SPD_REG_RUN_CUR)
                run_cur_q <= reg_wdata[7:0];
            if (reg_addr == `SPD_REG_INTERP)
                interp_q <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
        end
    end

    // ------------------------------
    // drive state machine
    // ------------------------------
    assign idle_done = idle_cnt_q >= IDLE_CYC;

    // faults win; leaving needs a clear with sensors quiet
    always_ff @(posedge clk)
    begin
        if (rst)
            state_q <= spd_pkg::SPD_DISABLED;
        else if (fault_now && state_q != spd_pkg::SPD_FAULT)
            state_q <= spd_pkg::SPD_FAULT; // R12
        else
        begin
            case (state_q)
                spd_pkg::SPD_DISABLED:
                    if (enabled)
                        state_q <= spd_pkg::SPD_RUN; // R5
                spd_pkg::SPD_RUN:
                    if (!enabled)
                        state_q <= spd_pkg::SPD_DISABLED; // R5
                    else if (ctrl_q.idle_auto && idle_done)
                        state_q <= spd_pkg::SPD_STANDBY; // R8
                spd_pkg::SPD_STANDBY:
                    if (!enabled)
                        state_q <= spd_pkg::SPD_DISABLED;
                    else if (accept || !ctrl_q.idle_auto)
                        state_q <= spd_pkg::SPD_RUN;
                spd_pkg::SPD_FAULT:
                    if (fault_clr && !fault_now)
                        state_q <= spd_pkg::SPD_DISABLED; // R12
                default:
                    state_q <= spd_pkg::SPD_DISABLED;
            endcase
        end
    end

    // idle timer restarts on any step or owed microstep
    always_ff @(posedge clk)
    begin
        if (rst)
            idle_cnt_q <= 32'h00000000;
        else if (state_q != spd_pkg::SPD_RUN || accept || pending_q != 24'sh000000)
            idle_cnt_q <= 32'h00000000;
        else if (!idle_done)
            idle_cnt_q <= idle_cnt_q + 32'h00000001; // R8
    end

    // ------------------------------
    // multi-stepping interpolator
    // ------------------------------
    // free-running tick; a burst may lag up to one spacing period,
    // traded for evenly timed microsteps
    always_ff @(posedge clk)
    begin
        if (rst)
            tick_cnt_q <= 16'h0000;
        else if (tick)
            tick_cnt_q <= 16'h0000;
        else
            tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
    assign tick = (tick_cnt_q + 16'h0001) >= interp_q;
    assign emit = tick && moving && (pending_q != 24'sh000000);

    // owed microsteps; a reversed step is netted against them, not cleared
    assign add_val = accept ? (in_fwd ? $signed({14'h0000, mult_q})
                                      : -$signed({14'h0000, mult_q})) : 24'sh000000;
    assign sub_val = emit ? (pending_q[23] ? -24'sh000001 : 24'sh000001) : 24'sh000000;

    always_ff @(posedge clk)
    begin
        if (rst)
            pending_q <= 24'sh000000;
        else if (!moving)
            pending_q <= 24'sh000000; // R13
        else
            pending_q <= pending_q + add_val - sub_val; // R11
    end

    // microstep pulse, direction beside it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            microstep_pulse <= 1'b0;
            microstep_dir <= 1'b0;
        end
        else
        begin
            microstep_pulse <= emit; // R11
            if (emit)
                microstep_dir <= ~pending_q[23];
        end
    end

    // signed position of issued microsteps
    always_ff @(posedge clk)
    begin
        if (rst)
            pos_q <= 32'sh00000000;
        else if (pos_clr)
            pos_q <= 32'sh00000000;
        else if (emit)
            pos_q <= pos_q + {{8{sub_val[23]}}, sub_val}; // R13
    end

    // ------------------------------
    // input rate watch
    // ------------------------------
    // saturating gap counter
    always_ff @(posedge clk)
    begin
        if (rst)
            gap_cnt_q <= MIN_GAP_CYC;
        else if (accept)
            gap_cnt_q <= 32'h00000001;
        else if (gap_cnt_q < MIN_GAP_CYC)
            gap_cnt_q <= gap_cnt_q + 32'h00000001;
    end

    // ------------------------------
    // commanded current
    // ------------------------------
    assign idle_prod = run_cur_q * 6'(`SPD_IDLE_PCT);
    assign idle_cur = 8'(idle_prod / 14'(100));

    // zero current outside run and standby so a faulted bridge stays off
    always_ff @(posedge clk)
    begin
        if (rst)
            cmd_current <= 8'h00;
        else if (state_q == spd_pkg::SPD_RUN)
            cmd_current <= run_cur_q;
        else if (state_q == spd_pkg::SPD_STANDBY)
            cmd_current <= idle_cur; // R8
        else
            cmd_current <= 8'h00; // R12
    end

    // drive state flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            drive_active <= 1'b0;
            fault_active <= 1'b0;
        end
        else
        begin
            drive_active <= moving;
            fault_active <= (state_q == spd_pkg::SPD_FAULT); // R12
        end
    end

    // ------------------------------
    // events and interrupt
    // ------------------------------
    assign evt.over_voltage = sync_q[3] & ~prev_q[3];
    assign evt.over_current = sync_q[4] & ~prev_q[4];
    assign evt.phase_err = sync_q[5] & ~prev_q[5];
    assign evt.idle_enter = (state_q == spd_pkg::SPD_RUN) && ctrl_q.idle_auto &&
                            idle_done && enabled && !fault_now;
    assign evt.rate_err = accept && (gap_cnt_q < MIN_GAP_CYC); // R10

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            status_q <= 5'h00;
        else if (reg_wr && reg_addr == `SPD_REG_INT_CLR)
            status_q <= (status_q & ~reg_wdata[4:0]) | evt;
        else
            status_q <= status_q | evt;
    end

    // interrupt enable
    always_ff @(posedge clk)
    begin
        if (rst)
            int_en_q <= 5'h00;
        else if (reg_wr && reg_addr == `SPD_REG_INT_EN)
            int_en_q <= reg_wdata[4:0];
    end

    // level interrupt
    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(status_q & int_en_q);
    end

    // ------------------------------
    // register read
    // ------------------------------
    // data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (rst || !reg_rd)
            reg_rdata <= 32'h00000000;
        else
        begin
            case (reg_addr)
                `SPD_REG_CTRL: reg_rdata <= {26'h0000000, ctrl_q};
                `SPD_REG_MULT: reg_rdata <= {22'h000000, mult_q};
                `SPD_REG_RES: reg_rdata <= {15'h0000, res_q};
                `SPD_REG_RUN_CUR: reg_rdata <= {24'h000000, run_cur_q};
                `SPD_REG_INTERP: reg_rdata <= {16'h0000, interp_q};
                `SPD_REG_POS: reg_rdata <= pos_q;
                `SPD_REG_STATUS: reg_rdata <= {27'h0000000, status_q};
                `SPD_REG_INT_EN: reg_rdata <= {27'h0000000, int_en_q};
                `SPD_REG_DRIVE: reg_rdata <= {21'h000000, cmd_current, enabled,
                                              state_q};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule : spd_step_pulse_input_decoder

// file: spd_params.svh
/*
 * decoder constants: offsets, fields, resets, timing.
 * assumes inclusion by bare name.
 */
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define SPD_CLK_KHZ 50000
`define SPD_STEP_MAX_KHZ 200
`define SPD_MIN_GAP_CYC ((`SPD_CLK_KHZ + `SPD_STEP_MAX_KHZ - 1) / `SPD_STEP_MAX_KHZ)
`define SPD_IDLE_MS 500
`define SPD_IDLE_CYC (`SPD_IDLE_MS * `SPD_CLK_KHZ)
`define SPD_IDLE_PCT 60

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SPD_REG_CTRL 8'h00
`define SPD_REG_MULT 8'h04
`define SPD_REG_RES 8'h08
`define SPD_REG_RUN_CUR 8'h0c
`define SPD_REG_INTERP 8'h10
`define SPD_REG_POS 8'h14
`define SPD_REG_STATUS 8'h18
`define SPD_REG_INT_EN 8'h1c
`define SPD_REG_INT_CLR 8'h20
`define SPD_REG_DRIVE 8'h24

// ---------------------------------------------------------------
// control fields and reset values
// ---------------------------------------------------------------
`define SPD_CTRL_FAULT_CLR 6
`define SPD_CTRL_POS_CLR 7
`define SPD_CTRL_RST 6'h20
`define SPD_MULT_RST 10'h001
`define SPD_MULT_MAX 10'h200
`define SPD_RES_MIN 17'h000c8
`define SPD_RES_MAX 17'h19000
`define SPD_RES_RST 17'h000c8
`define SPD_RUN_CUR_RST 8'h80
`define SPD_INTERP_RST 16'h0032

`endif

// file: spd_pkg.sv
/*
 * decoder types: state, control word, events.
 * assumes nothing.
 */
package spd_pkg;

    // ---------------------------------------------------------------
    // drive state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SPD_DISABLED = 2'b00,
        SPD_RUN = 2'b01,
        SPD_STANDBY = 2'b10,
        SPD_FAULT = 2'b11
    } spd_state_t;

    // ---------------------------------------------------------------
    // control word, bit 5 down to bit 0
    // ---------------------------------------------------------------
    typedef struct packed {
        logic idle_auto;
        logic ena_invert;
        logic dir_invert;
        logic ccw_low;
        logic step_fall;
        logic double_mode;
    } spd_ctrl_t;

    // ---------------------------------------------------------------
    // events, bit 4 down to bit 0
    // ---------------------------------------------------------------
    typedef struct packed {
        logic rate_err;
        logic idle_enter;
        logic phase_err;
        logic over_current;
        logic over_voltage;
    } spd_evt_t;

endpackage : spd_pkg

// file: spd_pkg_order_note_unused.sv
/*
 * empty unit, holds no logic.
 * assumes nothing.
 */

// file: spd_dec_sva.sv
/*
 * checker of the decoder's port timing.
 * assumes binding to the decoder top.
 */
module spd_dec_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // sensors and strobes
    input wire logic over_voltage_in,
    input wire logic over_current_in,
    input wire logic phase_error_in,
    input wire logic reg_wr,
    // outputs watched
    input wire logic microstep_pulse,
    input wire logic microstep_dir,
    input wire logic [7:0] cmd_current,
    input wire logic drive_active,
    input wire logic fault_active,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // -----------------------------------------------------------
    // sequences
    // -----------------------------------------------------------
    // a sensor held long enough to pass the two sync stages
    sequence s_sensor_held;
        (over_voltage_in || over_current_in || phase_error_in) [*3];
    endsequence
    sequence s_fault_settled;
        fault_active && $past(fault_active);
    endsequence

    // -----------------------------------------------------------
    // assertions
    // -----------------------------------------------------------
    chk_sensor_trips_fault: assert property (s_sensor_held |-> ##[0:4] fault_active)
        else $error("fault not entered after sensor");
    chk_fault_cuts_current: assert property (s_fault_settled |-> cmd_current == 8'h00)
        else $error("current left on in fault");
    chk_fault_excludes_run: assert property (!(fault_active && drive_active))
        else $error("fault and drive both active");
    // only a write may release the fault
    chk_fault_holds_on: assert property (fault_active && !reg_wr && !$past(reg_wr) |=> fault_active)
        else $error("fault released without a write");
    chk_pulse_needs_drive: assert property (microstep_pulse |-> drive_active || $past(drive_active))
        else $error("microstep while drive inactive");
    chk_dir_with_pulse: assert property ($changed(microstep_dir) |-> ##[0:1] microstep_pulse)
        else $error("direction moved without a microstep");
    chk_off_no_current: assert property (!drive_active && !$past(drive_active) |-> cmd_current == 8'h00)
        else $error("current commanded while off");
    chk_reset_quiet: assert property ($past(rst) |-> !drive_active && !fault_active && !irq)
        else $error("outputs active right after reset");
endmodule : spd_dec_sva

bind spd_step_pulse_input_decoder spd_dec_sva CHK (
    .clk(clk), .rst(rst), .over_voltage_in(over_voltage_in), .over_current_in(over_current_in),
    .phase_error_in(phase_error_in), .reg_wr(reg_wr), .microstep_pulse(microstep_pulse),
    .microstep_dir(microstep_dir), .cmd_current(cmd_current), .drive_active(drive_active),
    .fault_active(fault_active), .irq(irq));

// file: spd_host_model.sv
/*
 * host controller model: drives the command pins.
 * assumes one clock shared with the drive.
 */
module spd_host_model (
    // clock
    input wire logic clk,
    // pins toward the drive
    output logic step_pulse_in,
    output logic dir_in,
    output logic drive_enable_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // 250-cycle pulse period, never above 200 kHz
    localparam int HALF = 125;

    // idle pins; an open enable reads high
    initial
    begin
        step_pulse_in = 1'b0;
        dir_in = 1'b0;
        drive_enable_in = 1'b1;
    end

    // static levels; the long wait keeps direction ahead of the next edge
    task set_pins(input logic s, input logic d, input logic e);
        @(posedge clk);
        step_pulse_in <= s;
        dir_in <= d;
        drive_enable_in <= e;
        repeat (HALF * 2) @(posedge clk);
    endtask : set_pins

    // n pulses on step, or on direction in double mode
    task pulses(input int n, input bit on_dir);
        repeat (n * 2)
        begin
            @(posedge clk);
            if (on_dir)
                dir_in <= !dir_in;
            else
                step_pulse_in <= !step_pulse_in;
            repeat (HALF - 1) @(posedge clk);
        end
    endtask : pulses
endmodule : spd_host_model

// file: spd_step_pulse_input_decoder_tb_top.sv
/*
 * decoder bench: registers, pulse modes, enable, idle, faults.
 * assumes the host model and checker are built with it.
 */
module spd_step_pulse_input_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic step_pulse_in, dir_in, drive_enable_in;
    logic [2:0] sensors = 3'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, d, p;
    logic microstep_pulse, microstep_dir, drive_active, fault_active, irq;
    logic [7:0] cmd_current;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;

    // -----------------------------------------------------------
    // instances
    // -----------------------------------------------------------
    spd_host_model HOST (.clk(clk), .step_pulse_in(step_pulse_in), .dir_in(dir_in),
        .drive_enable_in(drive_enable_in));
    // short idle count keeps the standby scenario brief
    spd_step_pulse_input_decoder #(.IDLE_CYC(20)) DUT (.clk(clk), .rst(rst),
        .step_pulse_in(step_pulse_in), .dir_in(dir_in), .drive_enable_in(drive_enable_in),
        .over_voltage_in(sensors[0]), .over_current_in(sensors[1]), .phase_error_in(sensors[2]),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .microstep_pulse(microstep_pulse), .microstep_dir(microstep_dir),
        .cmd_current(cmd_current), .drive_active(drive_active), .fault_active(fault_active),
        .irq(irq));

    initial
    begin
        forever #10 clk = !clk;
    end

    // -----------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------
    task stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task check(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // data taken at the edge that ends its one standing cycle
    task reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
    endtask : reg_read

    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task t_reset();
        logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h30};
        logic [31:0] e [6] = '{32'h20, 32'h1, 32'hc8, 32'h80, 32'h32, 32'h0};
        foreach (a[i])
        begin
            reg_read(a[i], d);
            check("reset value", e[i], d);
        end
        reg_write(8'h08, 32'h1ffff);
        reg_read(8'h08, d);
        check("resolution ceiling", 32'h19000, d);
        $display("test reset finished");
    endtask : t_reset

    // four microsteps per step, out and back
    task t_single();
        reg_write(8'h04, 32'h4);
        reg_write(8'h10, 32'h2);
        reg_write(8'h00, 32'ha0);
        HOST.set_pins(1'b0, 1'b1, 1'b1);
        HOST.pulses(3, 1'b0);
        reg_read(8'h14, p);
        check("single position", 32'd12, p);
        HOST.set_pins(1'b0, 1'b0, 1'b1);
        HOST.pulses(3, 1'b0);
        reg_read(8'h14, p);
        check("single return", 32'd0, p);
        $display("test single finished");
    endtask : t_single

    task t_double();
        reg_write(8'h00, 32'ha1);
        HOST.set_pins(1'b0, 1'b0, 1'b1);
        HOST.pulses(2, 1'b0);
        HOST.pulses(1, 1'b1);
        reg_read(8'h14, p);
        check("double net", 32'd4, p);
        HOST.pulses(1, 1'b1);
        reg_read(8'h14, p);
        check("double back", 32'd0, p);
        reg_write(8'h00, 32'h20);
        $display("test double finished");
    endtask : t_double

    // standby current is floor(0x80 * 60 / 100) = 0x4c
    task t_idle();
        reg_write(8'h1c, 32'h08);
        reg_write(8'h20, 32'h1f);
        HOST.pulses(1, 1'b0);
        reg_read(8'h24, d);
        check("standby state", 32'h2, {30'h0, d[1:0]});
        check("standby current", 32'h4c, {24'h0, d[10:3]});
        check("idle irq", 32'h1, {31'h0, irq});
        reg_write(8'h20, 32'h08);
        repeat (3) @(posedge clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        $display("test idle finished");
    endtask : t_idle

    task t_enable();
        HOST.set_pins(1'b0, 1'b0, 1'b0);
        reg_read(8'h14, p);
        HOST.pulses(1, 1'b0);
        reg_read(8'h14, d);
        check("disabled position", p, d);
        reg_write(8'h00, 32'h30);
        repeat (10) @(posedge clk);
        check("inverted enable", 32'h1, {31'h0, drive_active});
        reg_write(8'h00, 32'h20);
        HOST.set_pins(1'b0, 1'b0, 1'b1);
        $display("test enable finished");
    endtask : t_enable

    // each sensor: latch, refuse steps, report, clear
    task t_fault();
        for (int i = 0; i < 3; i++)
        begin
            reg_read(8'h14, p);
            @(posedge clk);
            sensors <= 3'h1 << i;
            repeat (10) @(posedge clk);
            check("fault flag", 32'h1, {31'h0, fault_active});
            check("fault current", 32'h0, {24'h0, cmd_current});
            HOST.pulses(1, 1'b0);
            reg_read(8'h14, d);
            check("fault position", p, d);
            reg_read(8'h18, d);
            check("fault status", 32'h1 << i, d & (32'h1 << i));
            sensors <= 3'h0;
            repeat (3) @(posedge clk); // synchroniser must see them low
            reg_write(8'h00, 32'h60);
            repeat (5) @(posedge clk);
            check("fault cleared", 32'h0, {31'h0, fault_active});
        end
        $display("test fault finished");
    endtask : t_fault

    // -----------------------------------------------------------
    // main sequence and hang guard
    // -----------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_single();
        t_double();
        t_idle();
        t_enable();
        t_fault();
        stop_test();
    end

    // about 5,200 cycles are needed; nearly four times that means a hang
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end
endmodule : spd_step_pulse_input_decoder_tb_top
